//--- include/cofg_pkg.sv
// Constants, field layouts and types of the close-onto-fault guard.
// Assumes a single 20 MHz system clock and an APB register port.
package cofg_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

  // ************************************************************
  // Sizes and reset values
  // ************************************************************
  localparam int WIN_W = 21;
  localparam logic [WIN_W-1:0] WIN_MAX_MS = 21'h1b7740;
  localparam logic [WIN_W-1:0] WIN_RST_MS = 21'h0003e8;
  localparam int SG_NUM = 8;
  localparam int SG_W = 3;
  localparam int TRIG_NUM = 4;
  localparam int LOG_DEPTH = 12;
  localparam int LOG_AGE_W = 4;
  localparam int TS_W = 32;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_REMAIN = 8'h08;
  localparam logic [7:0] OFS_ELAPSED = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_LOG_SEL = 8'h18;
  localparam logic [7:0] OFS_LOG_TS = 8'h1c;
  localparam logic [7:0] OFS_LOG_INFO = 8'h20;
  localparam logic [7:0] OFS_LOG_REM = 8'h24;
  localparam logic [7:0] OFS_LOG_ELAP = 8'h28;
  localparam logic [7:0] OFS_WIN_BASE = 8'h40;
  localparam logic [7:0] OFS_WIN_END = 8'h60;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FEN_BIT = 4;
  localparam int CTRL_FSEL_LSB = 5;
  localparam int CTRL_STORE_LSB = 8;
  localparam int STAT_BLK_BIT = 4;
  localparam int STAT_SG_LSB = 8;
  localparam int INFO_SG_LSB = 4;
  localparam int LSEL_CNT_LSB = 8;
  localparam logic [2:0] MODE_ON = 3'h1;
  localparam logic [2:0] MODE_BLK = 3'h2;
  localparam logic [2:0] MODE_TEST = 3'h3;
  localparam logic [2:0] MODE_TESTBLK = 3'h4;
  localparam logic [2:0] MODE_OFF = 3'h5;
  localparam logic [1:0] FORCE_NORMAL = 2'h0;
  localparam logic [1:0] FORCE_BLOCKED = 2'h1;
  localparam logic [1:0] FORCE_ACTIVE = 2'h2;
  localparam logic [1:0] FORCE_TRIP = 2'h3;
  localparam logic [2:0] COND_NORMAL = 3'h0;
  localparam logic [2:0] COND_INIT = 3'h1;
  localparam logic [2:0] COND_ACTIVE = 3'h2;
  localparam logic [2:0] COND_TRIP = 3'h3;
  localparam logic [2:0] COND_BLOCKED = 3'h4;
  localparam logic [1:0] STORE_RST = 2'h3;
  // Flag order; event 2*f is the flag's ON event, 2*f+1 its OFF event.
  localparam int FL_INIT = 0;
  localparam int FL_BLK = 1;
  localparam int FL_ACT = 2;
  localparam int FL_TRIP = 3;
  localparam int EV_ACT_ON = 4;
  localparam logic [7:0] EV_ON_MASK = 8'h55;
  localparam logic [7:0] EV_LOG_MASK = 8'h54;

  typedef enum logic [2:0] {ST_NORMAL, ST_INIT, ST_ACTIVE, ST_TRIP, ST_BLOCKED} cofg_state_t;

  typedef struct packed {
    logic [TS_W-1:0] ts;
    logic [2:0] evt;
    logic [SG_W-1:0] sg;
    logic [WIN_W-1:0] rem;
    logic [WIN_W-1:0] elap;
  } cofg_rec_t;

endpackage

//--- include/cofg_log_if.sv
// Write and read port between the guard core and its record log.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface cofg_log_if;
  import cofg_pkg::*;
  logic wr_valid;
  cofg_rec_t wr_rec;
  logic [LOG_AGE_W-1:0] rd_age;
  cofg_rec_t rd_rec;
  logic [LOG_AGE_W-1:0] count;
  modport writer (output wr_valid, output wr_rec, output rd_age, input rd_rec, input count);
  modport store (input wr_valid, input wr_rec, input rd_age, output rd_rec, output count);
endinterface

//--- design/cofg_event_log.sv
// Rolling log of the most recent time-stamped guard records.
// Assumes writes arrive on clk_sys at most one per enabled cycle.
`timescale 1ns/1ps
module cofg_event_log
  import cofg_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  cofg_log_if.store lg
);

  localparam int AW = $clog2(DEPTH);

  cofg_rec_t mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [LOG_AGE_W-1:0] cnt_ff;
  logic [AW-1:0] rd_slot;

  // Age 0 is the newest record; the oldest one is overwritten when full.
  always_comb begin
    int s;
    s = int'(wptr_ff) + DEPTH - 1 - int'(lg.rd_age);
    if (s >= DEPTH) begin
      s = s - DEPTH;
    end
    rd_slot = AW'(s);
  end

  assign lg.rd_rec = (lg.rd_age < cnt_ff) ? mem[rd_slot] : '0;
  assign lg.count = cnt_ff;

  always_ff @(posedge clk_sys) begin
    if (ce && lg.wr_valid) begin
      mem[wptr_ff] <= lg.wr_rec;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wptr_ff <= '0;
      cnt_ff <= '0;
    end else if (ce && lg.wr_valid) begin
      wptr_ff <= (int'(wptr_ff) == DEPTH - 1) ? '0 : AW'(int'(wptr_ff) + 1);
      if (int'(cnt_ff) < DEPTH) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule

//--- design/cofg_top.sv
// Close-onto-fault guard: arms a release window on an activate edge and
// trips at once if any protection start arrives while the window runs.
// Assumes APB on clk_sys and binary inputs from pins of other domains.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module cofg_top
  import cofg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int TRIG_N = TRIG_NUM
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic activate_in,
  input wire logic block_in,
  input wire logic [TRIG_N-1:0] trigger_in,
  input wire logic [SG_W-1:0] setting_group,
  input wire logic [TS_W-1:0] ts_ms,
  output logic blocked_out,
  output logic active_out,
  output logic trip_out,
  output logic [7:0] evt_pulse,
  output logic [TS_W-1:0] evt_ts,
  output logic [SG_W-1:0] evt_sg,
  output logic [WIN_W-1:0] evt_rem,
  output logic [WIN_W-1:0] evt_elap,
  output logic irq
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Only binary levels enter the guard; there is no analog path.
  logic act_s1_ff, act_s2_ff, act_prev_ff;
  logic blk_s1_ff, blk_s2_ff;
  logic [TRIG_N-1:0] trig_s1_ff, trig_s2_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      act_s1_ff <= 1'b0;
      act_s2_ff <= 1'b0;
      act_prev_ff <= 1'b0;
      blk_s1_ff <= 1'b0;
      blk_s2_ff <= 1'b0;
      trig_s1_ff <= '0;
      trig_s2_ff <= '0;
    end else if (ce) begin
      act_s1_ff <= activate_in;
      act_s2_ff <= act_s1_ff;
      act_prev_ff <= act_s2_ff;
      blk_s1_ff <= block_in;
      blk_s2_ff <= blk_s1_ff;
      trig_s1_ff <= trigger_in;
      trig_s2_ff <= trig_s1_ff;
    end
  end

  // ************************************************************
  // Registers and decode
  // ************************************************************
  logic [2:0] mode_ff;
  logic force_en_ff;
  logic [1:0] force_sel_ff;
  logic [1:0] store_sel_ff;
  logic [WIN_W-1:0] win_ff [SG_NUM];
  logic [7:0] irq_stat_ff, irq_mask_ff;
  logic [LOG_AGE_W-1:0] log_sel_ff;
  logic [31:0] prdata_ff;
  logic rdv_ff, err_ff;
  logic [31:0] rd_word;
  logic rd_hit;
  cofg_state_t state_ff, nxt_state;
  logic [3:0] flags_ff, nxt_flags;
  logic [2:0] cond_ff, nxt_cond;
  logic trip_pin_ff;
  logic [7:0] evt_raw_ff, nxt_evt;
  logic [WIN_W-1:0] elap_ff, nxt_elap;
  logic [31:0] tick_cnt_ff;
  logic [TS_W-1:0] evt_ts_ff;
  logic [SG_W-1:0] evt_sg_ff;
  logic [WIN_W-1:0] evt_rem_ff, evt_elap_ff;
  cofg_log_if lg();

  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m >= MODE_ON) && (m <= MODE_OFF);
  endfunction

  wire logic wr_en = psel && penable && pready && pwrite;
  wire logic is_win = (paddr >= OFS_WIN_BASE) && (paddr < OFS_WIN_END) && (paddr[1:0] == 2'h0);
  wire logic [SG_W-1:0] win_idx = paddr[4:2];
  wire logic [WIN_W-1:0] win_wval = (pwdata > 32'(WIN_MAX_MS)) ? WIN_MAX_MS : pwdata[WIN_W-1:0];
  wire logic [2:0] wr_mode = pwdata[CTRL_MODE_LSB+:3];

  // The mode and the window are read live, so a group switch rescales a running window.
  wire logic run = (mode_ff != MODE_OFF);
  wire logic blk_eff = run && (blk_s2_ff || mode_ff == MODE_BLK || mode_ff == MODE_TESTBLK);
  wire logic act_rise = act_s2_ff && !act_prev_ff;
  wire logic trig_any = |trig_s2_ff;
  wire logic tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
  wire logic [WIN_W-1:0] win_cur = win_ff[setting_group];
  wire logic expired = (elap_ff >= win_cur);
  wire logic [WIN_W-1:0] remaining = expired ? '0 : win_cur - elap_ff;
  wire logic counting = (state_ff == ST_INIT) || (state_ff == ST_ACTIVE) || (state_ff == ST_TRIP);
  wire logic arm = act_rise && (nxt_state == ST_INIT);

  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    unique case (paddr)
      OFS_CTRL: rd_word = {22'h0, store_sel_ff, 1'b0, force_sel_ff, force_en_ff, 1'b0, mode_ff};
      OFS_STATUS: rd_word = {21'h0, setting_group, 1'b0, trip_pin_ff, active_out, blocked_out, 1'b0, cond_ff};
      OFS_REMAIN: rd_word = 32'(remaining);
      OFS_ELAPSED: rd_word = 32'(elap_ff);
      OFS_IRQ_STAT: rd_word = 32'(irq_stat_ff);
      OFS_IRQ_MASK: rd_word = 32'(irq_mask_ff);
      OFS_LOG_SEL: rd_word = {20'h0, lg.count, 4'h0, log_sel_ff};
      OFS_LOG_TS: rd_word = lg.rd_rec.ts;
      OFS_LOG_INFO: rd_word = {25'h0, lg.rd_rec.sg, 1'b0, lg.rd_rec.evt};
      OFS_LOG_REM: rd_word = 32'(lg.rd_rec.rem);
      OFS_LOG_ELAP: rd_word = 32'(lg.rd_rec.elap);
      default: begin
        rd_hit = is_win;
        rd_word = is_win ? 32'(win_ff[win_idx]) : '0;
      end
    endcase
  end

  // Data is captured one cycle ahead, so the access phase never waits while ce is high.
  assign pready = ce && rdv_ff;
  assign prdata = prdata_ff;
  assign pslverr = psel && penable && pready && err_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdv_ff <= 1'b0;
      err_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (ce) begin
      rdv_ff <= psel && !(penable && rdv_ff);
      err_ff <= !rd_hit;
      prdata_ff <= (psel && !pwrite) ? rd_word : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= MODE_ON;
      force_en_ff <= 1'b0;
      force_sel_ff <= FORCE_NORMAL;
      store_sel_ff <= STORE_RST;
      irq_mask_ff <= '0;
      log_sel_ff <= '0;
      for (int i = 0; i < SG_NUM; i++) begin
        win_ff[i] <= WIN_RST_MS;
      end
    end else if (ce && wr_en && !err_ff) begin
      if (paddr == OFS_CTRL) begin
        if (mode_legal(wr_mode)) begin
          mode_ff <= wr_mode;
        end
        force_en_ff <= pwdata[CTRL_FEN_BIT];
        force_sel_ff <= pwdata[CTRL_FSEL_LSB+:2];
        store_sel_ff <= pwdata[CTRL_STORE_LSB+:2];
      end
      if (paddr == OFS_IRQ_MASK) begin
        irq_mask_ff <= pwdata[7:0];
      end
      if (paddr == OFS_LOG_SEL) begin
        log_sel_ff <= pwdata[LOG_AGE_W-1:0];
      end
      if (is_win) begin
        win_ff[win_idx] <= win_wval;
      end
    end
  end

  // ************************************************************
  // Guard sequence
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    if (!run) begin
      nxt_state = ST_NORMAL;
    end else if (blk_eff) begin
      nxt_state = ST_BLOCKED;
    end else begin
      unique case (state_ff)
        ST_NORMAL: begin
          if (act_rise) nxt_state = ST_INIT;
        end
        ST_BLOCKED: begin
          nxt_state = act_rise ? ST_INIT : ST_NORMAL;
        end
        ST_INIT: begin
          if (act_rise) nxt_state = ST_INIT;
          else if (expired) nxt_state = ST_NORMAL;
          else if (trig_any) nxt_state = ST_TRIP;
          else if (tick) nxt_state = ST_ACTIVE;
        end
        ST_ACTIVE: begin
          if (act_rise) nxt_state = ST_INIT;
          else if (expired) nxt_state = ST_NORMAL;
          else if (trig_any) nxt_state = ST_TRIP;
        end
        ST_TRIP: begin
          if (!trig_any) nxt_state = expired ? ST_NORMAL : ST_ACTIVE;
        end
      endcase
    end
  end

  // Elapsed time restarts on every arm and saturates at the release time.
  always_comb begin
    nxt_elap = elap_ff;
    if (arm) begin
      nxt_elap = '0;
    end else if (tick && counting && !expired) begin
      nxt_elap = elap_ff + 1'b1;
    end
  end

  always_comb begin
    nxt_flags = '0;
    nxt_cond = COND_NORMAL;
    if (force_en_ff) begin
      unique case (force_sel_ff)
        FORCE_NORMAL: nxt_cond = COND_NORMAL;
        FORCE_BLOCKED: begin
          nxt_flags[FL_BLK] = 1'b1;
          nxt_cond = COND_BLOCKED;
        end
        FORCE_ACTIVE: begin
          nxt_flags[FL_ACT] = 1'b1;
          nxt_cond = COND_ACTIVE;
        end
        FORCE_TRIP: begin
          nxt_flags[FL_ACT] = 1'b1;
          nxt_flags[FL_TRIP] = 1'b1;
          nxt_cond = COND_TRIP;
        end
      endcase
    end else begin
      unique case (nxt_state)
        ST_NORMAL: nxt_cond = COND_NORMAL;
        ST_INIT: begin
          nxt_flags[FL_INIT] = 1'b1;
          nxt_cond = COND_INIT;
        end
        ST_ACTIVE: begin
          nxt_flags[FL_ACT] = 1'b1;
          nxt_cond = COND_ACTIVE;
        end
        ST_TRIP: begin
          nxt_flags[FL_ACT] = 1'b1;
          nxt_flags[FL_TRIP] = 1'b1;
          nxt_cond = COND_TRIP;
        end
        ST_BLOCKED: begin
          nxt_flags[FL_BLK] = 1'b1;
          nxt_cond = COND_BLOCKED;
        end
      endcase
    end
    for (int f = 0; f < 4; f++) begin
      nxt_evt[2*f] = nxt_flags[f] && !flags_ff[f];
      nxt_evt[2*f+1] = !nxt_flags[f] && flags_ff[f];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_NORMAL;
      flags_ff <= '0;
      cond_ff <= COND_NORMAL;
      trip_pin_ff <= 1'b0;
      evt_raw_ff <= '0;
      elap_ff <= '0;
      tick_cnt_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      flags_ff <= nxt_flags;
      cond_ff <= nxt_cond;
      // Test mode shows the trip in status and events but keeps the breaker pin quiet.
      trip_pin_ff <= nxt_flags[FL_TRIP] && (mode_ff != MODE_TEST);
      evt_raw_ff <= nxt_evt;
      elap_ff <= nxt_elap;
      tick_cnt_ff <= (tick || arm) ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  // ************************************************************
  // Events, process data, log and interrupt
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      evt_ts_ff <= '0;
      evt_sg_ff <= '0;
      evt_rem_ff <= '0;
      evt_elap_ff <= '0;
    end else if (ce && (|nxt_evt)) begin
      evt_ts_ff <= ts_ms;
      evt_sg_ff <= setting_group;
      evt_rem_ff <= remaining;
      evt_elap_ff <= elap_ff;
    end
  end

  wire logic [7:0] store_mask = (store_sel_ff[0] ? EV_ON_MASK : 8'h00) | (store_sel_ff[1] ? ~EV_ON_MASK : 8'h00);
  assign evt_pulse = ce ? (evt_raw_ff & store_mask) : 8'h00;
  assign evt_ts = evt_ts_ff;
  assign evt_sg = evt_sg_ff;
  assign evt_rem = evt_rem_ff;
  assign evt_elap = evt_elap_ff;
  assign blocked_out = flags_ff[FL_BLK];
  assign active_out = flags_ff[FL_ACT];
  assign trip_out = trip_pin_ff;

  // ON events can coincide: a step from init into trip raises ACT and TRIP ON together, and the record keeps only the TRIP ON code.
  wire logic [7:0] log_evt = evt_raw_ff & EV_LOG_MASK;
  assign lg.wr_valid = |log_evt;
  assign lg.wr_rec.ts = evt_ts_ff;
  assign lg.wr_rec.evt = log_evt[6] ? 3'h6 : (log_evt[4] ? 3'h4 : 3'h2);
  assign lg.wr_rec.sg = evt_sg_ff;
  assign lg.wr_rec.rem = evt_rem_ff;
  assign lg.wr_rec.elap = evt_elap_ff;
  assign lg.rd_age = log_sel_ff;

  cofg_event_log #(.DEPTH(LOG_DEPTH)) u_log (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .lg(lg.store)
  );

  // A new event in the clearing cycle stays set.
  wire logic [7:0] irq_w1c = (wr_en && !err_ff && paddr == OFS_IRQ_STAT) ? pwdata[7:0] : 8'h00;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_stat_ff <= '0;
    end else if (ce) begin
      irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | evt_raw_ff;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_arm_on_edge: assert property (ce && run && !blk_eff && state_ff == ST_NORMAL && act_rise |=>
    state_ff == ST_INIT && elap_ff == '0) else $error("activate edge did not arm");
  a_window_ends: assert property (ce && run && !blk_eff && state_ff == ST_ACTIVE && expired && !act_rise |=>
    state_ff == ST_NORMAL) else $error("window did not end at release time");
  a_trip_instant: assert property (ce && run && !blk_eff && state_ff == ST_ACTIVE && !expired && trig_any
    && !act_rise |=> state_ff == ST_TRIP && (flags_ff[FL_TRIP] || $past(force_en_ff))) else $error("late trip");
  a_trip_cause: assert property ((state_ff == ST_TRIP) && !$past(state_ff == ST_TRIP) |->
    $past(|trig_s2_ff)) else $error("trip without trigger");
  a_block_holds: assert property (ce && blk_eff |=> state_ff == ST_BLOCKED) else $error("block ignored");
  a_mode_legal: assert property (mode_legal(mode_ff)) else $error("illegal mode");
  a_force_trip: assert property (ce && force_en_ff && force_sel_ff == FORCE_TRIP |=>
    flags_ff[FL_TRIP] && cond_ff == COND_TRIP) else $error("forced trip missing");
  a_cond_blocked: assert property (blocked_out |-> cond_ff == COND_BLOCKED) else $error("bad condition");
  a_act_event: assert property ($rose(active_out) |-> evt_raw_ff[EV_ACT_ON] && lg.wr_valid)
    else $error("active ON event or record missing");

endmodule

//--- bench/cofg_far_end.sv
// Model of the breaker close command and the protection starts feeding the guard.
// Assumes the bench calls its tasks just after a rising edge of clk_sys.
`timescale 1ns/1ps
module cofg_far_end
  import cofg_pkg::*;
(
  input wire logic clk_sys,
  output logic activate_in,
  output logic block_in,
  output logic [TRIG_NUM-1:0] trigger_in
);
  // ************************************************************
  // Stimulus tasks
  // ************************************************************
  initial begin
    activate_in = 1'b0;
    block_in = 1'b0;
    trigger_in = '0;
  end
  // The close pulse spans three edges so that the two-stage synchroniser sees it.
  task automatic close_breaker();
    activate_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    activate_in <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic set_block(input logic v);
    block_in <= v;
    @(posedge clk_sys);
  endtask
  task automatic prot_start(input int idx, input logic v);
    trigger_in[idx] <= v;
    @(posedge clk_sys);
  endtask
endmodule

//--- bench/test_close_onto_fault_guard.sv
// Self-checking bench of the close-onto-fault guard over its APB port.
// Assumes a shortened millisecond tick of four clocks.
`timescale 1ns/1ps
module test_close_onto_fault_guard;
  import cofg_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic activate_in;
  logic block_in;
  logic [TRIG_NUM-1:0] trigger_in;
  logic [SG_W-1:0] setting_group = 3'h0;
  logic blocked_out;
  logic active_out;
  logic trip_out;
  logic irq;
  logic ce = 1'b1;
  logic [7:0] evt_pulse;
  logic [TS_W-1:0] evt_ts;
  logic [SG_W-1:0] evt_sg;
  logic [WIN_W-1:0] evt_rem;
  logic [WIN_W-1:0] evt_elap;
  logic [7:0] ev_seen = 8'h00;
  logic [31:0] d;
  logic e;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;

  always #25 clk_sys = ~clk_sys;

  cofg_top #(.TICK_CYCLES(4), .TRIG_N(TRIG_NUM)) uut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .activate_in(activate_in), .block_in(block_in),
    .trigger_in(trigger_in), .setting_group(setting_group), .ts_ms(32'h0000_1234),
    .blocked_out(blocked_out), .active_out(active_out), .trip_out(trip_out), .evt_pulse(evt_pulse),
    .evt_ts(evt_ts), .evt_sg(evt_sg), .evt_rem(evt_rem), .evt_elap(evt_elap), .irq(irq));
  cofg_far_end far (.clk_sys(clk_sys), .activate_in(activate_in), .block_in(block_in),
    .trigger_in(trigger_in));

  // ************************************************************
  // Access and compare tasks
  // ************************************************************
  // Right after an edge the design's flops still show what stood at that edge, so the answer is taken there.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic wait_active(input logic v);
    for (int i = 0; i < 100 && active_out !== v; i++) @(posedge clk_sys);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle event pulses are gathered so that none is missed between checks.
  always @(posedge clk_sys) begin
    ev_seen <= ev_seen | evt_pulse;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0000_0301, d);
    apb(1'b0, OFS_WIN_BASE, 32'h0);
    chk("win0", 32'h0000_03e8, d);
    apb(1'b0, 8'h30, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b1, OFS_WIN_BASE + 8'h08, 32'hffff_ffff);
    apb(1'b0, OFS_WIN_BASE + 8'h08, 32'h0);
    chk("win_clamp", 32'h001b_7740, d);
    apb(1'b1, OFS_IRQ_MASK, 32'h10);
    apb(1'b1, OFS_WIN_BASE, 32'h3);
    far.close_breaker();
    wait_active(1'b1);
    chk("active", 32'h1, {31'h0, active_out});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("cond_active", 32'h2, d & 32'h7);
    chk("irq", 32'h1, {31'h0, irq});
    far.prot_start(2, 1'b1);
    for (int i = 0; i < 20 && trip_out !== 1'b1; i++) @(posedge clk_sys);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("cond_trip", 32'h3, d & 32'h7);
    far.prot_start(2, 1'b0);
    wait_active(1'b0);
    chk("active_end", 32'h0, {31'h0, active_out});
    apb(1'b0, OFS_LOG_SEL, 32'h0);
    chk("log_count", 32'h2, (d >> LSEL_CNT_LSB) & 32'hf);
    apb(1'b0, OFS_LOG_INFO, 32'h0);
    chk("log_info", 32'h6, d & 32'h7f);
    apb(1'b0, OFS_LOG_REM, 32'h0);
    chk("log_rem", 32'h1, d);
    apb(1'b0, OFS_LOG_ELAP, 32'h0);
    chk("log_elap", 32'h2, d);
    apb(1'b0, OFS_LOG_TS, 32'h0);
    chk("log_ts", 32'h0000_1234, d);
    chk("evt_seen", 32'hf3, {24'h0, ev_seen});
    chk("evt_ts", 32'h0000_1234, evt_ts);
    chk("evt_rem", 32'h0, {11'h0, evt_rem});
    chk("evt_elap", 32'h3, {11'h0, evt_elap});
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h10, d & 32'h10);
    apb(1'b1, OFS_IRQ_STAT, 32'hff);
    chk("irq_clr", 32'h0, {31'h0, irq});
    setting_group <= 3'h1;
    apb(1'b1, OFS_WIN_BASE + 8'h04, 32'h0);
    far.close_breaker();
    repeat (5) @(posedge clk_sys);
    chk("sg_zero_win", 32'h0, {31'h0, active_out});
    chk("evt_sg", 32'h1, {29'h0, evt_sg});
    setting_group <= 3'h0;
    far.set_block(1'b1);
    far.close_breaker();
    repeat (5) @(posedge clk_sys);
    chk("blk_active", 32'h0, {31'h0, active_out});
    chk("blk_out", 32'h1, {31'h0, blocked_out});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("cond_blk", 32'h4, d & 32'h7);
    far.set_block(1'b0);
    apb(1'b1, OFS_CTRL, 32'h306);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("mode_bad", 32'h301, d);
    apb(1'b1, OFS_CTRL, 32'h305);
    far.close_breaker();
    repeat (5) @(posedge clk_sys);
    chk("mode_off", 32'h0, {31'h0, active_out});
    apb(1'b1, OFS_CTRL, 32'h371);
    repeat (5) @(posedge clk_sys);
    chk("force_trip", 32'h1, {31'h0, trip_out});
    apb(1'b1, OFS_CTRL, 32'h373);
    repeat (5) @(posedge clk_sys);
    chk("test_pin", 32'h0, {31'h0, trip_out});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("test_cond", 32'h3, d & 32'h7);
    apb(1'b1, OFS_CTRL, 32'h302);
    repeat (2) @(posedge clk_sys);
    chk("mode_blk", 32'h1, {31'h0, blocked_out});
    apb(1'b1, OFS_CTRL, 32'h301);
    ce <= 1'b0;
    far.close_breaker();
    ce <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("ce_freeze", 32'h0, {31'h0, active_out});
    final_report();
  end
endmodule
